// [hdl/edac_host.sv]
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - write: lanes input, check port driven out
// - release bus before enabling lane drivers
// - byte write: hold latch, raise modified lanes
// - return selects low for fresh check word
module edac_host (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output edac_ctrl_pkg::edac_pins_type pins,
  input wire edac_ctrl_pkg::edac_sense_type sense
);

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_WR_SET = 10'h002,
    ST_WR_GEN = 10'h004,
    ST_RD_SET = 10'h008,
    ST_RD_HOLD = 10'h010,
    ST_RD_TURN = 10'h020,
    ST_RD_CORR = 10'h040,
    ST_RMW_LAT = 10'h080,
    ST_RMW_GEN = 10'h100,
    ST_DONE = 10'h200
  } state_type;

  state_type state_q;
  logic [7:0] cnt_q;
  logic [31:0] ctrl_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [6:0] check_q;
  logic serr_q;
  logic multi_fault_flag_n_q;
  logic done_q;
  logic go_pulse;
  edac_ctrl_pkg::op_type op;
  logic [3:0] lanes;
  logic [6:0] chk_in;
  logic [31:0] ctrl_now;
  edac_ctrl_pkg::edac_sense_type sense_q;
  edac_ctrl_pkg::edac_pins_type pins_q;

  // the go cycle must steer by the new order, ctrl_q only holds it one edge later
  assign ctrl_now = go_pulse ? {hwdata[31:1], 1'b0} : ctrl_q;
  assign op = edac_ctrl_pkg::op_type'(ctrl_now[edac_ctrl_pkg::CTRL_OP_LSB +: 2]);
  assign lanes = ctrl_now[edac_ctrl_pkg::CTRL_LANE_LSB +: 4];
  assign chk_in = ctrl_now[edac_ctrl_pkg::CTRL_CHK_LSB +: 7];
  assign pins = pins_q;

  pin_sync #(
    .WIDTH($bits(edac_ctrl_pkg::edac_sense_type))
  ) sense_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(sense),
    .pin_q(sense_q)
  );

  // ------------------------------------------------------------
  // ahb-lite slave
  // ------------------------------------------------------------
  logic ap_valid;
  logic dp_write_q;
  logic [7:0] dp_addr_q;

  assign ap_valid = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dp_write_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      dp_write_q <= ap_valid && hwrite;
      dp_addr_q <= haddr[7:0];
    end
  end

  assign go_pulse = dp_write_q && (dp_addr_q == edac_ctrl_pkg::CTRL_OFFSET) &&
                    hwdata[edac_ctrl_pkg::CTRL_GO_BIT] && (state_q == ST_IDLE);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= edac_ctrl_pkg::CTRL_RESET;
      wdata_q <= 32'h0000_0000;
    end else if (dp_write_q && state_q == ST_IDLE) begin
      if (dp_addr_q == edac_ctrl_pkg::CTRL_OFFSET) begin
        ctrl_q <= {hwdata[31:1], 1'b0};
      end else if (dp_addr_q == edac_ctrl_pkg::WDATA_OFFSET) begin
        wdata_q <= hwdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      if (haddr[7:0] == edac_ctrl_pkg::CTRL_OFFSET) begin
        hrdata <= ctrl_q;
      end else if (haddr[7:0] == edac_ctrl_pkg::WDATA_OFFSET) begin
        hrdata <= wdata_q;
      end else if (haddr[7:0] == edac_ctrl_pkg::STATUS_OFFSET) begin
        hrdata <= {28'h0000000, done_q, multi_fault_flag_n_q, serr_q, state_q != ST_IDLE};
      end else if (haddr[7:0] == edac_ctrl_pkg::RDATA_OFFSET) begin
        hrdata <= rdata_q;
      end else if (haddr[7:0] == edac_ctrl_pkg::CHECK_OFFSET) begin
        hrdata <= {25'h0000000, check_q};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
    end else begin
      if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
      case (state_q)
        ST_IDLE: begin
          if (go_pulse) begin
            cnt_q <= 8'(edac_ctrl_pkg::SETUP_CYC + 2);
            if (op == edac_ctrl_pkg::OP_WRITE) begin
              state_q <= ST_WR_SET;
            end else begin
              state_q <= ST_RD_SET;
            end
          end
        end
        ST_WR_SET: begin
          state_q <= ST_WR_GEN;
          cnt_q <= 8'(edac_ctrl_pkg::CHECK_CYC + 3);
        end
        ST_WR_GEN, ST_RMW_GEN: begin
          if (cnt_q == 8'h00) begin
            state_q <= ST_DONE;
          end
        end
        ST_RD_SET: begin
          if (cnt_q == 8'h00) begin
            state_q <= ST_RD_HOLD;
            cnt_q <= 8'(edac_ctrl_pkg::HOLD_CYC);
          end
        end
        ST_RD_HOLD: begin
          if (cnt_q == 8'h00) begin
            state_q <= ST_RD_TURN;
          end
        end
        ST_RD_TURN: begin
          state_q <= ST_RD_CORR;
          cnt_q <= 8'(edac_ctrl_pkg::CORR_CYC + edac_ctrl_pkg::LATCH_CYC + 3);
        end
        ST_RD_CORR: begin
          if (cnt_q == 8'h00) begin
            if (op == edac_ctrl_pkg::OP_RMW) begin
              state_q <= ST_RMW_LAT;
              cnt_q <= 8'h02;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_RMW_LAT: begin
          if (cnt_q == 8'h00) begin
            state_q <= ST_RMW_GEN;
            cnt_q <= 8'(edac_ctrl_pkg::CHECK_CYC + 3);
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pins_q <= '0;
      pins_q.byte_lane_output_enable_n <= 4'hF;
      pins_q.check_port_output_enable_n <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          pins_q.data_oe <= 4'h0;
          pins_q.check_oe <= 1'b0;
          pins_q.data_out_latch_enable <= 1'b0;
          pins_q.byte_lane_output_enable_n <= 4'hF;
          pins_q.check_port_output_enable_n <= 1'b1;
          if (go_pulse) begin
            pins_q.mode_select_b1 <= (op != edac_ctrl_pkg::OP_WRITE);
            pins_q.mode_select_b0 <= 1'b0;
            pins_q.data_out <= wdata_q;
            pins_q.data_oe <= 4'hF;
            pins_q.check_out <= chk_in;
            pins_q.check_oe <= (op != edac_ctrl_pkg::OP_WRITE);
            pins_q.check_port_output_enable_n <= (op != edac_ctrl_pkg::OP_WRITE);
          end
        end
        ST_RD_SET: begin
          if (cnt_q == 8'h00) begin
            pins_q.mode_select_b0 <= 1'b1;
            pins_q.mode_select_b1 <= (op != edac_ctrl_pkg::OP_DIAG);
          end
        end
        ST_RD_HOLD: begin
          if (cnt_q == 8'h00) begin
            pins_q.data_oe <= 4'h0;
            pins_q.check_oe <= 1'b0;
          end
        end
        ST_RD_TURN: begin
          pins_q.byte_lane_output_enable_n <= 4'h0;
          if (op != edac_ctrl_pkg::OP_DIAG) begin
            pins_q.check_port_output_enable_n <= 1'b0;
          end
        end
        ST_RD_CORR: begin
          if (cnt_q == 8'h00 && op == edac_ctrl_pkg::OP_RMW) begin
            pins_q.data_out_latch_enable <= 1'b1;
            pins_q.check_port_output_enable_n <= 1'b1;
          end
        end
        ST_RMW_LAT: begin
          if (cnt_q == 8'h00) begin
            pins_q.byte_lane_output_enable_n <= lanes;
            pins_q.data_out <= wdata_q;
            pins_q.data_oe <= lanes;
            pins_q.mode_select_b0 <= 1'b0;
            pins_q.mode_select_b1 <= 1'b0;
            pins_q.check_port_output_enable_n <= 1'b0;
          end
        end
        ST_DONE: begin
          pins_q.mode_select_b0 <= 1'b0;
          pins_q.mode_select_b1 <= 1'b0;
        end
        default: begin
          pins_q.data_oe <= pins_q.data_oe;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // result capture
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
      check_q <= 7'h00;
      serr_q <= 1'b0;
      multi_fault_flag_n_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (go_pulse) begin
        done_q <= 1'b0;
      end else if (state_q == ST_DONE) begin
        done_q <= 1'b1;
      end
      if ((state_q == ST_RD_HOLD) && (cnt_q == 8'h00)) begin
        serr_q <= !sense_q.single_fault_flag_n;
        multi_fault_flag_n_q <= !sense_q.multi_fault_flag_n;
      end
      if ((state_q == ST_RD_CORR) && (cnt_q == 8'h00)) begin
        rdata_q <= sense_q.data_port_bit;
        check_q <= sense_q.check_word_bit;
      end
      if ((state_q == ST_WR_GEN || state_q == ST_RMW_GEN) && cnt_q == 8'h00) begin
        check_q <= sense_q.check_word_bit;
      end
    end
  end

endmodule

// [hdl/edac_ctrl_pkg.sv]
package edac_ctrl_pkg;

  // ------------------------------------------------------------
  // controller register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] WDATA_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] RDATA_OFFSET = 8'h0C;
  localparam logic [7:0] CHECK_OFFSET = 8'h10;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_LANE_LSB = 4;
  localparam int CTRL_CHK_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SERR_BIT = 1;
  localparam int STAT_MULTI_FAULT_FLAG_N_BIT = 2;
  localparam int STAT_DONE_BIT = 3;

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETUP_NS = 5;
  localparam int HOLD_NS = 10;
  localparam int CHECK_GEN_NS = 30;
  localparam int CORRECT_NS = 37;
  localparam int LATCH_AFTER_S0_NS = 30;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHECK_CYC = (CHECK_GEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CORR_CYC = (CORRECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_CYC = (LATCH_AFTER_S0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_RMW = 2'h2,
    OP_DIAG = 2'h3
  } op_type;

  // pins toward the device
  typedef struct packed {
    logic mode_select_b1;
    logic mode_select_b0;
    logic [3:0] byte_lane_output_enable_n;
    logic data_out_latch_enable;
    logic check_port_output_enable_n;
    logic [31:0] data_out;
    logic [3:0] data_oe;
    logic [6:0] check_out;
    logic check_oe;
  } edac_pins_type;

  typedef struct packed {
    logic [31:0] data_port_bit;
    logic [6:0] check_word_bit;
    logic single_fault_flag_n;
    logic multi_fault_flag_n;
  } edac_sense_type;

endpackage

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 41
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync width must be positive");
  end

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// [sim/edac_dev_model.sv]
`timescale 1ns/1ps
module edac_dev_model (
  input wire edac_ctrl_pkg::edac_pins_type pins,
  output edac_ctrl_pkg::edac_sense_type sense
);
  logic [31:0] din, dout, dbus, corr;
  logic [6:0] cin, syn, cbus;
  logic b1, b0, single;
  // column k is the k-th weight-3 code, so one data error never looks like two
  function automatic logic [6:0] code_of(input int k);
    int n;
    n = 0;
    for (int v = 0; v < 128; v++) begin
      if ($countones(7'(v)) == 3) begin
        if (n == k) return 7'(v);
        n++;
      end
    end
    return 7'h00;
  endfunction
  function automatic logic [6:0] gen_check(input logic [31:0] d);
    logic [6:0] c;
    c = 7'h07;
    for (int k = 0; k < 32; k++) begin
      if (d[k]) c = c ^ code_of(k);
    end
    return c;
  endfunction
  assign b1 = pins.mode_select_b1;
  assign b0 = pins.mode_select_b0;
  // lane drivers; an undriven lane shows the inverse of the host value
  always @* begin
    for (int l = 0; l < 4; l++) begin
      if (pins.data_oe[l]) dbus[8*l+:8] = pins.data_out[8*l+:8];
      else if (!pins.byte_lane_output_enable_n[l]) dbus[8*l+:8] = dout[8*l+:8];
      else dbus[8*l+:8] = ~pins.data_out[8*l+:8];
    end
  end
  assign cbus = pins.check_oe ? pins.check_out : !pins.check_port_output_enable_n ?
    ((b1 && b0) ? syn : gen_check(din)) : ~pins.check_out;
  always @* if (!(b1 && b0)) din = dbus;
  always @* if (b1 && !b0) cin = cbus;
  always @* begin
    syn = gen_check(din) ^ cin;
    corr = din;
    single = ($countones(syn) == 1);
    for (int k = 0; k < 32; k++) begin
      if (syn == code_of(k)) begin
        corr[k] = ~din[k];
        single = 1'b1;
      end
    end
  end
  // output latch, corrected only in correct mode
  always @* if (!pins.data_out_latch_enable) dout = (b1 && b0) ? corr : din;
  assign sense = {dbus, cbus, !(b1 | b0) | (syn == 7'h00),
    !(b1 | b0) | (syn == 7'h00) | single};
endmodule

// [sim/edac_host_properties.sv]
`timescale 1ns/1ps
module edac_host_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire edac_ctrl_pkg::edac_pins_type pins
);
  logic mixed, wr_mode, rd_drive;
  assign mixed = pins.data_oe != 4'h0 && pins.byte_lane_output_enable_n != 4'hF;
  assign wr_mode = !pins.mode_select_b1 && !pins.mode_select_b0;
  assign rd_drive = pins.data_oe == 4'hF && pins.check_oe;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_bus_okay: assert property (!hresp && hreadyout) else $error("bus answer not okay");
  chk_lane_clash: assert property (
    (pins.data_oe & ~pins.byte_lane_output_enable_n) == 4'h0) else $error("lane contention");
  chk_check_clash: assert property (
    pins.check_oe |-> pins.check_port_output_enable_n) else $error("check port contention");
  chk_write_check: assert property (
    wr_mode && pins.data_oe == 4'hF |-> ##[0:4] !pins.check_port_output_enable_n)
    else $error("check port not enabled in write");
  chk_setup_b0: assert property (
    $rose(pins.mode_select_b0) |-> $past(rd_drive)) else $error("no setup before b0");
  chk_hold_b0: assert property (
    $rose(pins.mode_select_b0) |-> rd_drive [*2]) else $error("hold after b0 too short");
  chk_release_first: assert property (
    $fell(pins.byte_lane_output_enable_n[0]) |-> !$past(pins.data_oe[0]))
    else $error("lane enabled before release");
  chk_merge_latched: assert property (
    mixed |-> pins.data_out_latch_enable) else $error("merge without held latch");
  chk_merge_mode: assert property (
    mixed |-> ##[0:4] wr_mode) else $error("merge not followed by write mode");
  cov_read: cover property ($rose(pins.mode_select_b0));
  cov_merge: cover property (mixed);
  cov_fresh: cover property (wr_mode && !pins.check_port_output_enable_n);
endmodule
bind edac_host edac_host_properties u_props (.clk(clk), .reset_n(reset_n),
  .hreadyout(hreadyout), .hresp(hresp), .pins(pins));

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  typedef struct {
    edac_ctrl_pkg::op_type op;
    logic [31:0] d;
    logic [6:0] ck;
    logic [3:0] lanes;
    logic [31:0] exp_rd;
    logic [6:0] exp_ck;
    logic [1:0] exp_fl;
    logic [2:0] m;
  } row_type;
  logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, st, dv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [6:0] g;
  edac_ctrl_pkg::edac_pins_type pins;
  edac_ctrl_pkg::edac_sense_type sense;
  int fail_count = 0, check_count = 0;
  row_type rows[9];
  edac_host uut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .sense(sense));
  edac_dev_model u_dev (.pins(pins), .sense(sense));
  always #2.5 clk = ~clk;
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic go(input edac_ctrl_pkg::op_type op, input logic [31:0] d,
    input logic [6:0] ck, input logic [3:0] lanes);
    ahb(1'b1, edac_ctrl_pkg::WDATA_OFFSET, d, rd);
    ahb(1'b1, edac_ctrl_pkg::CTRL_OFFSET, {17'h0, ck, lanes, 1'b0, op, 1'b1}, rd);
  endtask
  task automatic wait_done(output logic [31:0] q);
    q = 32'h0;
    for (int n = 0; n < 200 && q[edac_ctrl_pkg::STAT_DONE_BIT] !== 1'b1; n++) begin
      ahb(1'b0, edac_ctrl_pkg::STATUS_OFFSET, 32'h0, q);
    end
    // a poll limit that runs out counts as a mismatch
    cmp("done_seen", 32'h1, {31'h0, q[edac_ctrl_pkg::STAT_DONE_BIT]});
  endtask
  initial begin
    dv = 32'h5A3C_96E1;
    g = u_dev.gen_check(dv);
    rows[0] = '{edac_ctrl_pkg::OP_WRITE, dv, 7'h00, 4'h0, 32'h0, g, 2'h0, 3'h2};
    rows[1] = '{edac_ctrl_pkg::OP_WRITE, 32'h0, 7'h00, 4'h0, 32'h0, 7'h07, 2'h0, 3'h2};
    rows[2] = '{edac_ctrl_pkg::OP_READ, dv, g, 4'h0, dv, 7'h00, 2'h0, 3'h7};
    rows[3] = '{edac_ctrl_pkg::OP_READ, dv ^ 32'h8000_0000, g, 4'h0, dv,
      u_dev.code_of(31), 2'h1, 3'h7};
    rows[4] = '{edac_ctrl_pkg::OP_READ, dv, g ^ 7'h40, 4'h0, dv, 7'h40, 2'h1, 3'h7};
    rows[5] = '{edac_ctrl_pkg::OP_READ, dv ^ 32'h3, g, 4'h0, dv ^ 32'h3,
      u_dev.code_of(0) ^ u_dev.code_of(1), 2'h3, 3'h7};
    rows[6] = '{edac_ctrl_pkg::OP_DIAG, dv ^ 32'h20, g, 4'h0, 32'h0, 7'h00, 2'h1, 3'h1};
    rows[7] = '{edac_ctrl_pkg::OP_DIAG, dv ^ 32'h300, g, 4'h0, 32'h0, 7'h00, 2'h3, 3'h1};
    rows[8] = '{edac_ctrl_pkg::OP_RMW, dv ^ 32'h0800_0000, g, 4'h8, 32'h0,
      u_dev.gen_check(dv ^ 32'h0800_0000), 2'h0, 3'h2};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    ahb(1'b0, edac_ctrl_pkg::CTRL_OFFSET, 32'h0, rd);
    cmp("ctrl_reset", edac_ctrl_pkg::CTRL_RESET, rd);
    ahb(1'b0, edac_ctrl_pkg::STATUS_OFFSET, 32'h0, rd);
    cmp("status_reset", 32'h0, rd);
    cmp("lanes_idle", 32'hF, {28'h0, pins.byte_lane_output_enable_n});
    foreach (rows[i]) begin
      go(rows[i].op, rows[i].d, rows[i].ck, rows[i].lanes);
      wait_done(st);
      if (rows[i].m[0]) cmp("status", {28'h0, 1'b1, rows[i].exp_fl, 1'b0}, st);
      if (rows[i].m[2]) begin
        ahb(1'b0, edac_ctrl_pkg::RDATA_OFFSET, 32'h0, rd);
        cmp("rdata", rows[i].exp_rd, rd);
      end
      if (rows[i].m[1]) begin
        ahb(1'b0, edac_ctrl_pkg::CHECK_OFFSET, 32'h0, rd);
        cmp("check", {25'h0, rows[i].exp_ck}, rd);
      end
    end
    // orders given while busy must leave the running read untouched
    go(edac_ctrl_pkg::OP_READ, dv, g, 4'h0);
    go(edac_ctrl_pkg::OP_WRITE, 32'h0, 7'h00, 4'h0);
    wait_done(st);
    ahb(1'b0, edac_ctrl_pkg::RDATA_OFFSET, 32'h0, rd);
    cmp("busy_rdata", dv, rd);
    ahb(1'b0, edac_ctrl_pkg::CHECK_OFFSET, 32'h0, rd);
    cmp("busy_check", 32'h0, rd);
    ahb(1'b0, 8'h14, 32'h0, rd);
    cmp("unmapped_resp", 32'h0, {31'h0, hresp});
    cmp("unmapped_rdata", 32'h0, rd);
    // reset lands in the middle of a read-modify-write
    go(edac_ctrl_pkg::OP_RMW, dv, g, 4'h1);
    repeat (6) @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    cmp("lanes_rereset", 32'hF, {28'h0, pins.byte_lane_output_enable_n});
    ahb(1'b0, edac_ctrl_pkg::CTRL_OFFSET, 32'h0, rd);
    cmp("ctrl_rereset", edac_ctrl_pkg::CTRL_RESET, rd);
    ahb(1'b0, edac_ctrl_pkg::STATUS_OFFSET, 32'h0, rd);
    cmp("status_rereset", 32'h0, rd);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule
